// *** hdl/nvmspc_pkg.sv ***
// Shared constants and types for the nonvolatile self-program control block
package nvmspc_pkg;
   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_KEY = 8'h04;
   localparam logic [7:0] ADR_LOC = 8'h08;
   localparam logic [7:0] ADR_VAL = 8'h0C;
   localparam logic [7:0] ADR_STAT = 8'h10;
   localparam logic [7:0] ADR_PTR = 8'h14;
   localparam logic [7:0] ADR_LATCH = 8'h18;
   // Control register fields
   localparam int B_CODE = 7;
   localparam int B_CFG = 6;
   localparam int B_ERASE = 4;
   localparam int B_PERMIT = 2;
   localparam int B_GO = 1;
   localparam int B_RDGO = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hD4;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Status register fields
   localparam int S_DONE = 0;
   localparam int S_BUSY = 1;
   localparam int S_PWRT = 2;
   // Unlock keys
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // Table pointer block field
   localparam int PTR_W = 22;
   localparam int BLK_LSB = 6;
   localparam int BLK_W = 16;
   // Timing: one tick is one microsecond
   localparam int TMR_W = 17;
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int ERASE_TIME_US = 2000;
   localparam int EEWR_TIME_US = 4000;
   localparam int PWRT_TIME_MS = 72;
   localparam logic [TMR_W-1:0] ERASE_TICKS_DFLT = TMR_W'(ERASE_TIME_US * 1000 / TICK_NS);
   localparam logic [TMR_W-1:0] EEWR_TICKS_DFLT = TMR_W'(EEWR_TIME_US * 1000 / TICK_NS);
   localparam logic [TMR_W-1:0] PWRT_TICKS_DFLT = TMR_W'(PWRT_TIME_MS * 1000000 / TICK_NS);
   // Main sequencer states
   typedef enum logic [1:0] {ST_PWRT, ST_IDLE, ST_EWRITE, ST_ERASE} nvmspc_st_e;
   // Unlock tracker states
   typedef enum logic [1:0] {KEY_WAIT1, KEY_WAIT2, KEY_ARMED} nvmspc_key_e;
   // Flash erase request towards the program memory
   typedef struct packed {
      logic active;
      logic [BLK_W-1:0] block;
   } nvmspc_erase_s;
endpackage

// *** hdl/nvmspc_timer.sv ***
// Programming timer: microsecond tick divider and tick down-counter
`timescale 1ns/1ps
`default_nettype none
module nvmspc_timer import nvmspc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [TMR_W-1:0] len_i,
   output logic done_o
);
   typedef struct packed {
      logic [4:0] pre;
      logic [TMR_W-1:0] left;
      logic done;
   } nvmspc_tmr_s;
   nvmspc_tmr_s r;
   nvmspc_tmr_s n;
   logic tick;

   // Divider pulse once per microsecond, then count ticks down
   always_comb begin
      n = r;
      n.done = 1'b0;
      tick = (r.pre == 5'(TICK_CYC - 1));
      n.pre = tick ? 5'h00 : r.pre + 5'h01;
      if (start_i) begin
         n.pre = 5'h00;
         n.left = len_i;
      end else if (tick && r.left != '0) begin
         n.left = r.left - TMR_W'(1);
         n.done = (r.left == TMR_W'(1));
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done_o = r.done;
endmodule // nvmspc_timer
`default_nettype wire

// *** hdl/nvmspc_top.sv ***
// Self-program control for flash block erase and data EEPROM access
// What this block does
// [R1] Firmware erase works on whole 64-byte blocks of 32 words only.
// [R2] Erase block comes from table pointer bits 21..6; bits 5..0 ignored.
// [R3] No single-word erase and no bulk erase from firmware.
// [R4] Software sets code space, clears config space, sets permit and erase.
// [R5] Erase ignores the holding latch contents.
// [R6] A cycle starts only after keys 55h then AAh, then go.
// [R7] Flash erase stalls the CPU until the programming timer ends it.
// [R8] The erase stall lasts about 2 ms.
// [R9] Read go with code space clear gives data on the next cycle.
// [R10] Value register keeps read data until next read or software write.
// [R11] Software loads location and value before the unlock keys.
// [R12] Writes refused without permit; hardware never clears permit.
// [R13] Software should disable interrupts around the key and go writes.
// [R14] Software should keep permit clear except while updating memory.
// [R15] After erase go software runs one no-op; the CPU is stalled.
// [R16] Completion clears go and sets the done flag; software clears it.
// [R17] Go needs permit already set by an earlier write.
// [R18] Control, location and value writes are ignored while a cycle runs.
// [R19] Permit clear at power-up; no EEPROM write during power-up timer.
// [R20] Keys must be consecutive key port writes; any other write restarts.
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module nvmspc_top import nvmspc_pkg::*; #(
   parameter logic [TMR_W-1:0] PWRT_TICKS = PWRT_TICKS_DFLT,
   parameter logic [TMR_W-1:0] ERASE_TICKS = ERASE_TICKS_DFLT,
   parameter logic [TMR_W-1:0] EEWR_TICKS = EEWR_TICKS_DFLT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic cpu_stall_o,
   output nvmspc_erase_s erase_o
);
   typedef struct packed {
      nvmspc_st_e st;
      nvmspc_key_e key;
      logic [7:0] ctrl;
      logic [7:0] loc;
      logic [7:0] val;
      logic [7:0] latch;
      logic [PTR_W-1:0] ptr;
      logic done;
      logic ack;
      logic [7:0] dat;
      logic stall;
      nvmspc_erase_s erase;
      logic tstart;
      logic [TMR_W-1:0] tlen;
   } nvmspc_state_s;

   nvmspc_state_s r;
   nvmspc_state_s n;
   logic [7:0] mem [0:255];
   logic acc;
   logic wr;
   logic busy;
   logic tdone;
   logic mem_we;
   logic [7:0] wd;

   // Programming timer shared by power-up, erase and EEPROM write
   nvmspc_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(r.tstart),
      .len_i(r.tlen),
      .done_o(tdone)
   );

   // Bus decode helpers
   assign acc = wb_cyc_i && wb_stb_i && !r.ack;
   assign wr = acc && wb_we_i && wb_sel_i[0];
   assign wd = wb_dat_i[7:0];
   assign busy = (r.st == ST_EWRITE) || (r.st == ST_ERASE);
   assign mem_we = tdone && (r.st == ST_EWRITE);

   // Next state: bus access, unlock tracking, cycle start and completion
   always_comb begin
      n = r;
      n.tstart = 1'b0;
      n.ack = acc;
      n.dat = 8'h00;
      if (acc && !wb_we_i) begin
         unique case (wb_adr_i)
            ADR_CTRL: n.dat = {r.ctrl[7:3], r.ctrl[B_PERMIT], busy, 1'b0};
            ADR_LOC: n.dat = r.loc;
            ADR_VAL: n.dat = r.val;
            ADR_STAT: n.dat = {5'h00, (r.st == ST_PWRT), busy, r.done};
            ADR_PTR: n.dat = r.ptr[7:0];
            ADR_LATCH: n.dat = r.latch;
            default: n.dat = 8'h00;
         endcase
      end
      if (wr) begin
         // Any write other than a correct key restarts the tracker
         n.key = KEY_WAIT1; // see [R20]
         unique case (wb_adr_i)
            ADR_KEY: begin
               if (r.key == KEY_WAIT1 && wd == KEY_FIRST) begin
                  n.key = KEY_WAIT2; // see [R6]
               end else if (r.key == KEY_WAIT2 && wd == KEY_SECOND) begin
                  n.key = KEY_ARMED; // see [R6]
               end
            end
            ADR_CTRL: begin
               if (!busy) begin // see [R18]
                  // Permit only changes by software here
                  n.ctrl = (r.ctrl & ~CTRL_WMASK) | (wd & CTRL_WMASK); // see [R12]
                  if (wd[B_RDGO] && !wd[B_CODE]) begin
                     n.val = mem[r.loc]; // see [R9] see [R10]
                  end
                  // Go needs old permit, armed keys and an idle sequencer
                  if (wd[B_GO] && r.ctrl[B_PERMIT] && r.key == KEY_ARMED
                      && r.st == ST_IDLE && !wd[B_CFG]) begin // see [R17] see [R6] see [R19]
                     if (!wd[B_CODE]) begin
                        n.st = ST_EWRITE; // see [R12]
                        n.tstart = 1'b1;
                        n.tlen = EEWR_TICKS;
                     end else if (wd[B_ERASE]) begin // see [R4] see [R3]
                        n.st = ST_ERASE;
                        n.tstart = 1'b1;
                        n.tlen = ERASE_TICKS; // see [R8]
                        n.stall = 1'b1; // see [R7] see [R15]
                        n.erase.active = 1'b1;
                        // Whole block from the upper pointer bits, latch unused
                        n.erase.block = r.ptr[BLK_LSB +: BLK_W]; // see [R1] see [R2] see [R5]
                     end
                  end
               end
            end
            // Location and value freeze while a cycle runs
            ADR_LOC: begin
               if (!busy) begin
                  n.loc = wd; // see [R18]
               end
            end
            ADR_VAL: begin
               if (!busy) begin
                  n.val = wd; // see [R10] see [R18]
               end
            end
            // Writing one to the done bit clears it
            ADR_STAT: begin
               if (wd[S_DONE]) begin
                  n.done = 1'b0; // see [R16]
               end
            end
            // Pointer takes all 22 bits and reads back as its low byte
            ADR_PTR: begin
               if (!busy) begin
                  n.ptr = PTR_W'(wb_dat_i);
               end
            end
            // Holding latch is kept for software only; erase never reads it
            ADR_LATCH: n.latch = wd;
            default: n.latch = r.latch;
         endcase
      end
      // Timer end finishes the cycle; the flag set wins over a clear
      if (tdone) begin
         unique case (r.st)
            ST_PWRT: n.st = ST_IDLE; // see [R19]
            ST_EWRITE, ST_ERASE: begin
               n.st = ST_IDLE;
               n.done = 1'b1; // see [R16]
               n.stall = 1'b0; // see [R7]
               n.erase.active = 1'b0;
            end
            ST_IDLE: n.st = ST_IDLE;
         endcase
      end
   end

   // State register; power-up timer starts right after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.st <= ST_PWRT;
         r.key <= KEY_WAIT1;
         r.ctrl <= CTRL_RST; // see [R19]
         r.tstart <= 1'b1;
         r.tlen <= PWRT_TICKS;
      end else begin
         r <= n;
      end
   end

   // EEPROM array written when the write cycle completes
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[r.loc] <= r.val;
      end
   end

   // Outputs straight from the state register
   assign wb_dat_o = {24'h000000, r.dat};
   assign wb_ack_o = r.ack;
   assign cpu_stall_o = r.stall;
   assign erase_o = r.erase;

   // Checks next to the logic
   a_go_needs_permit: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
      (r.st == ST_IDLE ##1 (r.st == ST_EWRITE || r.st == ST_ERASE)) |-> $past(r.ctrl[B_PERMIT], 2))
      else $error("cycle started without earlier permit");
   a_keys_armed: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      (r.st == ST_IDLE ##1 r.st != ST_IDLE) |-> $past(r.key, 2) == KEY_ARMED)
      else $error("cycle started without unlock keys");
   a_erase_block: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
      erase_o.active |-> erase_o.block == r.ptr[21:6])
      else $error("erase block differs from pointer");
   a_stall_erase: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      (r.st == ST_ERASE) |-> (cpu_stall_o && erase_o.active))
      else $error("erase without stall");
   a_done_on_end: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
      (busy && tdone) |=> (r.done && r.st == ST_IDLE && !cpu_stall_o))
      else $error("completion not flagged");
   a_permit_kept: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
      (r.ctrl[B_PERMIT] && !(wr && wb_adr_i == ADR_CTRL)) |=> r.ctrl[B_PERMIT])
      else $error("permit cleared by hardware");
   a_pwrt_block: assert property (@(posedge clk_i) disable iff (rst_i) // see [R19]
      (r.st == ST_PWRT) |=> (r.st == ST_PWRT || r.st == ST_IDLE))
      else $error("write during power-up timer");
   a_read_next: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
      (wr && wb_adr_i == ADR_CTRL && wd[B_RDGO] && !wd[B_CODE] && !busy)
      |=> r.val == mem[$past(r.loc)])
      else $error("read data not ready next cycle");
   a_locked_loc: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
      (busy && wr && wb_adr_i == ADR_LOC) |=> $stable(r.loc))
      else $error("location changed during cycle");
   a_key_restart: assert property (@(posedge clk_i) disable iff (rst_i) // see [R20]
      (wr && wb_adr_i == ADR_KEY && wd != KEY_FIRST && wd != KEY_SECOND) |=> r.key == KEY_WAIT1)
      else $error("bad key did not restart tracker");
   a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");

   // Checks on locking, flags, the key tracker, erase setup, stall, reads, the data write and bus data
   // Permit starts clear and the power-up timer runs after reset
   a_permit_powerup: assert property (@(posedge clk_i) disable iff (rst_i) // see [R19]
      $past(rst_i) |-> (r.st == ST_PWRT && !r.ctrl[B_PERMIT]))
      else $error("permit set or timer idle after reset");
   // Go in the same write that sets permit never starts a cycle
   a_go_same_write: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
      (wr && wb_adr_i == ADR_CTRL && wd[B_GO] && !r.ctrl[B_PERMIT] && !busy) |=> !busy)
      else $error("go started a cycle without earlier permit");
   // Control writes bounce off a running cycle
   a_locked_ctrl: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
      (busy && wr && wb_adr_i == ADR_CTRL) |=> $stable(r.ctrl))
      else $error("control changed during cycle");
   // Value writes bounce off a running cycle
   a_locked_val: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
      (busy && wr && wb_adr_i == ADR_VAL) |=> $stable(r.val))
      else $error("value changed during cycle");
   // Pointer writes bounce off a running cycle
   a_locked_ptr: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
      (busy && wr && wb_adr_i == ADR_PTR) |=> $stable(r.ptr))
      else $error("pointer changed during cycle");
   // Only a code-space erase with erase select reaches the erase state
   a_erase_setup: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
      (r.st == ST_ERASE) |-> (r.ctrl[B_CODE] && r.ctrl[B_ERASE] && !r.ctrl[B_CFG]))
      else $error("erase without erase setup");
   // A data write never stalls the processor
   a_stall_only_erase: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      cpu_stall_o |-> (r.st == ST_ERASE))
      else $error("stall outside flash erase");
   // Done flag stays until software writes one to it
   a_done_kept: assert property (@(posedge clk_i) disable iff (rst_i) // see [R16]
      (r.done && !(wr && wb_adr_i == ADR_STAT && wd[S_DONE])) |=> r.done)
      else $error("done flag cleared by hardware");
   // Any write away from the key port restarts the tracker
   a_key_intervene: assert property (@(posedge clk_i) disable iff (rst_i) // see [R20]
      (wr && wb_adr_i != ADR_KEY) |=> r.key == KEY_WAIT1)
      else $error("tracker survived another write");
   // Second key after the first arms the tracker
   a_key_second: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      (wr && wb_adr_i == ADR_KEY && r.key == KEY_WAIT2 && wd == KEY_SECOND)
      |=> r.key == KEY_ARMED)
      else $error("key pair did not arm");
   // Erased block stays put for the whole erase
   a_block_held: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
      (erase_o.active && $past(erase_o.active)) |-> $stable(erase_o.block))
      else $error("erase block moved during erase");
   // Read go aimed at code space leaves the value register alone
   a_read_code: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      (wr && wb_adr_i == ADR_CTRL && wd[B_RDGO] && wd[B_CODE] && !busy) |=> $stable(r.val))
      else $error("code-space read changed value");
   // Completion of a data write lands the value at the location
   a_mem_written: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_we |=> mem[$past(r.loc)] == $past(r.val))
      else $error("data write did not land");
   // Read data is zero outside the ack cycle
   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
endmodule // nvmspc_top
`default_nettype wire

// *** bench/nvmspc_top_tb.sv ***
// Self-checking bench for the self-program control block over Wishbone
`timescale 1ns/1ps
`default_nettype none
module nvmspc_top_tb import nvmspc_pkg::*;;
   localparam int ER_T = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic cpu_stall_o;
   nvmspc_erase_s erase_o;
   int err_total = 0;
   int num_checks = 0;
   int n;
   logic [31:0] rd;
   logic [21:0] ptr_v = 22'h25ABCD;

   // Shortened power-up, erase and write times
   nvmspc_top #(.PWRT_TICKS(TMR_W'(5)), .ERASE_TICKS(TMR_W'(ER_T)),
      .EEWR_TICKS(TMR_W'(3))) u_nvmspc_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .cpu_stall_o(cpu_stall_o), .erase_o(erase_o));

   // Clock at 40 ns period
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   // Compares a value and counts the outcome
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single cycle; held until ack is sampled, then one idle cycle
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      dat <= d;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      // Waits for ack however long it takes; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   // Both unlock keys in order
   task automatic keys();
      wr(ADR_KEY, 32'h55);
      wr(ADR_KEY, 32'hAA);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake or poll
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(ADR_CTRL, 32'h0);
      rdc(ADR_STAT, 32'h4);
      wr(ADR_LOC, 32'h7);
      wr(ADR_CTRL, 32'h4);
      keys();
      wr(ADR_CTRL, 32'h6);
      rdc(ADR_STAT, 32'h4);
      n = 0;
      do begin
         xfer(ADR_STAT, 1'b0, 32'h0);
         n++;
      end while (rd[2] !== 1'b0 && n < 100);
      chk({31'h0, rd[2]}, 32'h0);
      wr(ADR_CTRL, 32'h0);
      keys();
      wr(ADR_CTRL, 32'h6);
      rdc(ADR_STAT, 32'h0);
      wr(ADR_CTRL, 32'h4);
      wr(ADR_KEY, 32'h55);
      wr(ADR_LOC, 32'h3);
      wr(ADR_KEY, 32'hAA);
      wr(ADR_CTRL, 32'h6);
      rdc(ADR_STAT, 32'h0);
      wr(ADR_KEY, 32'hAA);
      wr(ADR_KEY, 32'h55);
      wr(ADR_CTRL, 32'h6);
      rdc(ADR_STAT, 32'h0);
      // Data write, with updates attempted while it runs
      wr(ADR_VAL, 32'h5A);
      keys();
      wr(ADR_CTRL, 32'h6);
      rdc(ADR_STAT, 32'h2);
      wr(ADR_LOC, 32'h9);
      wr(ADR_VAL, 32'h33);
      wr(ADR_CTRL, 32'h0);
      n = 0;
      do begin
         xfer(ADR_STAT, 1'b0, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 100);
      rdc(ADR_STAT, 32'h1);
      rdc(ADR_CTRL, 32'h4);
      rdc(ADR_LOC, 32'h3);
      rdc(ADR_VAL, 32'h5A);
      wr(ADR_STAT, 32'h1);
      rdc(ADR_STAT, 32'h0);
      wr(ADR_VAL, 32'h0);
      rdc(ADR_VAL, 32'h0);
      wr(ADR_CTRL, 32'h1);
      rdc(ADR_VAL, 32'h5A);
      // Read go aimed at code space must leave the value alone
      wr(ADR_VAL, 32'h11);
      wr(ADR_CTRL, 32'h81);
      rdc(ADR_VAL, 32'h11);
      // Flash block erase; the latch holds a value that must not matter
      wr(ADR_PTR, {10'h0, ptr_v});
      wr(ADR_LATCH, 32'hC3);
      rdc(ADR_PTR, {24'h0, ptr_v[7:0]});
      rdc(ADR_LATCH, 32'hC3);
      wr(ADR_CTRL, 32'h94);
      keys();
      wr(ADR_CTRL, 32'h96);
      #1;
      chk({31'h0, cpu_stall_o}, 32'h1);
      chk({15'h0, erase_o}, {15'h0, 1'b1, ptr_v[21:6]});
      n = 0;
      while (cpu_stall_o === 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
         #1;
      end
      chk({31'h0, n >= ER_T * TICK_CYC - 3 && n <= (ER_T + 1) * TICK_CYC}, 32'h1);
      @(posedge clk_i);
      rdc(ADR_STAT, 32'h1);
      chk({31'h0, erase_o.active}, 32'h0);
      rdc(8'hFC, 32'h0);
      end_of_test();
   end
endmodule // nvmspc_top_tb
`default_nettype wire
